// [design/cpd_pkg.sv]
package cpd_pkg;

   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned TIMEOUT_MS = 100;
   localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);

   // -------------------------------------------------------------
   // register map (byte addresses)
   // -------------------------------------------------------------
   localparam logic [11:0] MEM_ADDR = 12'h000;
   localparam logic [11:0] CTRL_ADDR = 12'h100;
   localparam logic [11:0] STAT_ADDR = 12'h104;
   localparam int CTRL_START = 0;
   localparam int CTRL_PROTO = 1;
   localparam int CTRL_KIND = 2;
   localparam int CTRL_GROUP = 4;
   localparam int CTRL_NVARS = 8;
   localparam int STAT_BUSY = 0;
   localparam int STAT_DONE = 1;
   localparam int STAT_MON = 16;

   // -------------------------------------------------------------
   // word areas
   // -------------------------------------------------------------
   localparam logic [5:0] WR_AREA = 6'h00;
   localparam logic [5:0] RD_AREA = 6'h20;
   localparam logic [5:0] OPCMD_OFF = 6'h01;
   localparam logic [3:0] MAX_VARS = 4'hC;
   localparam logic [3:0] PM_CLR_FIRST = 4'h4;
   localparam logic [3:0] PM_CLR_LAST = 4'h9;
   localparam logic [3:0] NO_ITEM = 4'h8;
   localparam logic [2:0] GROUP_MAX = 3'h5;

   // -------------------------------------------------------------
   // monitor codes
   // -------------------------------------------------------------
   localparam logic [15:0] RSP_NORMAL = 16'h0000;
   localparam logic [15:0] RSP_PARAM_ERR = 16'h1100;
   localparam logic [7:0] ERR_UPPER = 8'hFF;
   localparam logic [15:0] RSP_CHK_ERR = 16'hFF97;
   localparam logic [15:0] TIMEOUT_CODE = 16'hFFFF;
   localparam logic [15:0] OPCMD_NO_SET = 16'h0600;

   // -------------------------------------------------------------
   // types
   // -------------------------------------------------------------
   typedef enum logic [7:0] {
      ERR_NONE = 8'h00,
      ERR_ADDR_OVF = 8'h04,
      ERR_NOEXEC = 8'h0D,
      ERR_PARITY = 8'h10,
      ERR_FRAMING = 8'h11,
      ERR_OVERRUN = 8'h12,
      ERR_CMD_CHK = 8'h13,
      ERR_FORMAT = 8'h14,
      ERR_NUMERIC = 8'h15,
      ERR_SUBADDR = 8'h16,
      ERR_FRAME_LEN = 8'h18,
      ERR_NVM_WRITE = 8'h21
   } cpd_err_t;

   typedef enum logic [1:0] {
      OP_WRITE_VAR,
      OP_COMMAND,
      OP_READ_ITEM
   } cpd_op_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_START,
      ST_CLEAR,
      ST_ISSUE,
      ST_WAIT,
      ST_STORE,
      ST_FIN
   } cpd_eng_t;

   typedef struct packed {
      cpd_op_t op;
      logic proto;
      logic kind;
      logic [3:0] index;
      logic [7:0] cmd;
      logic [7:0] info;
      logic [31:0] data;
   } cpd_req_t;

   typedef struct packed {
      cpd_err_t err;
      logic chk_ok;
      logic [15:0] resp_code;
      logic [31:0] data;
      logic [15:0] status;
   } cpd_rsp_t;

endpackage

// [design/cpd_rsp_eval.sv]
`timescale 1ns/100ps
module cpd_rsp_eval #(
   parameter int unsigned TIMEOUT_CYC = cpd_pkg::TIMEOUT_CYC
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // request taken, response in
   input wire logic arm,
   input wire logic rsp_valid,
   input wire cpd_pkg::cpd_rsp_t rsp,
   // result
   output logic done,
   output logic [15:0] code,
   output logic [31:0] data,
   output logic [15:0] status
);

   typedef struct packed {
      logic waiting;
      logic [31:0] cnt;
      logic done;
      logic [15:0] code;
      logic [31:0] data;
      logic [15:0] status;
   } cpd_ev_t;

   cpd_ev_t s_reg, s_next;

   always_comb begin
      s_next = s_reg;
      s_next.done = 1'b0;
      if (arm) begin
         s_next.waiting = 1'b1;
         s_next.cnt = 32'h0;
      end else if (s_reg.waiting) begin
         if (rsp_valid) begin
            s_next.waiting = 1'b0;
            s_next.done = 1'b1;
            s_next.data = rsp.data;
            s_next.status = rsp.status;
            if (rsp.err != cpd_pkg::ERR_NONE) begin
               s_next.code = {cpd_pkg::ERR_UPPER, rsp.err};
            end else if (!rsp.chk_ok) begin
               s_next.code = cpd_pkg::RSP_CHK_ERR;
            end else begin
               s_next.code = rsp.resp_code;
            end
         end else if (s_reg.cnt == 32'(TIMEOUT_CYC - 1)) begin
            s_next.waiting = 1'b0;
            s_next.done = 1'b1;
            s_next.code = cpd_pkg::TIMEOUT_CODE;
            s_next.data = 32'h0;
            s_next.status = 16'h0;
         end else begin
            s_next.cnt = s_reg.cnt + 32'h1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign done = s_reg.done;
   assign code = s_reg.code;
   assign data = s_reg.data;
   assign status = s_reg.status;

endmodule

// [design/cpd_engine.sv]
`timescale 1ns/100ps
module cpd_engine #(
   parameter int unsigned TIMEOUT_CYC = cpd_pkg::TIMEOUT_CYC
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // component link
   output logic req_valid,
   input wire logic req_ready,
   output cpd_pkg::cpd_req_t req,
   input wire logic rsp_valid,
   input wire cpd_pkg::cpd_rsp_t rsp
);

   typedef struct packed {
      logic [63:0][15:0] mem;
      logic awready;
      logic wready;
      logic arready;
      logic [11:0] awaddr;
      logic aw_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic w_got;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic proto;
      logic kind;
      logic [2:0] group;
      logic [3:0] nvars;
      logic busy;
      logic done;
      logic [15:0] last_mon;
      cpd_pkg::cpd_eng_t st;
      logic opphase;
      logic [3:0] idx;
      logic [1:0] wcnt;
      logic zero;
      logic [15:0] code;
      logic [31:0] data;
      logic [15:0] status;
      logic req_valid;
      cpd_pkg::cpd_req_t req;
   } cpd_state_t;

   cpd_state_t s_reg, s_next;
   logic ev_done;
   logic [15:0] ev_code;
   logic [31:0] ev_data;
   logic [15:0] ev_status;
   logic arm;

   // -------------------------------------------------------------
   // read item tables
   // -------------------------------------------------------------
   // kind 0 = temperature controller, 1 = panel meter
   function automatic logic [7:0] item_mask(input logic kind, input logic [2:0] group);
      logic [7:0] m;
      m = 8'h00;
      if (!kind) begin
         case (group)
            3'h1, 3'h2: m = 8'h03;
            3'h3: m = 8'h0F;
            3'h4: m = 8'h7F;
            3'h5: m = 8'hFF;
            default: m = 8'h00;
         endcase
      end else begin
         case (group)
            3'h1: m = 8'h01;
            3'h2, 3'h3: m = 8'h07;
            3'h4: m = 8'h79;
            3'h5: m = 8'h7F;
            default: m = 8'h00;
         endcase
      end
      return m;
   endfunction

   function automatic logic [4:0] item_off(input logic kind, input logic [3:0] idx);
      logic [4:0] o;
      o = 5'h00;
      if (!kind) begin
         if (idx == 4'h0) o = 5'h01;
         else if (idx == 4'h7) o = 5'h09;
         else o = 5'(idx) + 5'h02;
      end else begin
         if (idx < 4'h3) o = 5'h01 + 5'(idx) * 5'h03;
         else o = 5'h0A + (5'(idx) - 5'h03) * 5'h02;
      end
      return o;
   endfunction

   function automatic logic [1:0] item_nw(input logic kind, input logic [3:0] idx);
      logic [1:0] n;
      if (!kind) n = (idx == 4'h0 || idx == 4'h7) ? 2'h2 : 2'h1;
      else n = (idx < 4'h3) ? 2'h3 : 2'h2;
      return n;
   endfunction

   function automatic logic [3:0] next_item(input logic [7:0] mask, input logic [3:0] from);
      logic [3:0] r;
      r = cpd_pkg::NO_ITEM;
      for (int i = 7; i >= 0; i--) begin
         if (mask[i] && 4'(i) >= from) r = 4'(i);
      end
      return r;
   endfunction

   // -------------------------------------------------------------
   // response timing and classification
   // -------------------------------------------------------------
   assign arm = s_reg.req_valid && req_ready;

   cpd_rsp_eval #(
      .TIMEOUT_CYC(TIMEOUT_CYC)
   ) u_eval (
      .aclk(aclk),
      .aresetn(aresetn),
      .arm(arm),
      .rsp_valid(rsp_valid),
      .rsp(rsp),
      .done(ev_done),
      .code(ev_code),
      .data(ev_data),
      .status(ev_status)
   );

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   always_comb begin
      logic eng_wr;
      logic [15:0] opcmd;
      logic [3:0] last;
      logic [3:0] nxt;
      logic [5:0] a;
      logic [7:0] mask;
      logic [1:0] nw;
      eng_wr = 1'b0;
      opcmd = s_reg.mem[cpd_pkg::WR_AREA + cpd_pkg::OPCMD_OFF];
      last = (s_reg.nvars > cpd_pkg::MAX_VARS) ? cpd_pkg::MAX_VARS : s_reg.nvars;
      mask = item_mask(s_reg.kind, s_reg.group);
      nw = item_nw(s_reg.kind, s_reg.idx);
      nxt = next_item(mask, s_reg.idx + 4'h1);
      a = 6'h00;
      s_next = s_reg;
      if (s_reg.req_valid && req_ready) s_next.req_valid = 1'b0;

      case (s_reg.st)
         cpd_pkg::ST_IDLE: begin
         end
         cpd_pkg::ST_START: begin
            s_next.code = cpd_pkg::RSP_NORMAL;
            s_next.zero = 1'b0;
            s_next.wcnt = 2'h0;
            if (!s_reg.proto) begin
               s_next.idx = 4'h1;
               s_next.opphase = (opcmd == cpd_pkg::OPCMD_NO_SET) || (last == 4'h0);
               s_next.st = cpd_pkg::ST_ISSUE;
            end else if (s_reg.group == 3'h0 || s_reg.group > cpd_pkg::GROUP_MAX) begin
               s_next.code = cpd_pkg::RSP_PARAM_ERR;
               s_next.st = cpd_pkg::ST_FIN;
            end else if (s_reg.kind && s_reg.group == 3'h4) begin
               s_next.idx = cpd_pkg::PM_CLR_FIRST;
               s_next.st = cpd_pkg::ST_CLEAR;
            end else begin
               s_next.idx = next_item(mask, 4'h0);
               s_next.st = cpd_pkg::ST_ISSUE;
            end
         end
         cpd_pkg::ST_CLEAR: begin
            eng_wr = 1'b1;
            s_next.mem[cpd_pkg::RD_AREA + 6'(s_reg.idx)] = 16'h0000;
            if (s_reg.idx == cpd_pkg::PM_CLR_LAST) begin
               s_next.idx = next_item(mask, 4'h0);
               s_next.st = cpd_pkg::ST_ISSUE;
            end else begin
               s_next.idx = s_reg.idx + 4'h1;
            end
         end
         cpd_pkg::ST_ISSUE: begin
            s_next.req_valid = 1'b1;
            s_next.req.proto = s_reg.proto;
            s_next.req.kind = s_reg.kind;
            s_next.req.index = s_reg.idx;
            s_next.req.cmd = opcmd[15:8];
            s_next.req.info = opcmd[7:0];
            if (s_reg.proto) begin
               s_next.req.op = cpd_pkg::OP_READ_ITEM;
               s_next.req.data = 32'h0;
            end else if (s_reg.opphase) begin
               s_next.req.op = cpd_pkg::OP_COMMAND;
               s_next.req.data = 32'h0;
            end else begin
               s_next.req.op = cpd_pkg::OP_WRITE_VAR;
               s_next.req.data = {s_reg.mem[{1'b0, s_reg.idx, 1'b1}],
                                  s_reg.mem[{1'b0, s_reg.idx, 1'b0}]};
            end
            s_next.st = cpd_pkg::ST_WAIT;
         end
         cpd_pkg::ST_WAIT: begin
            if (ev_done) begin
               s_next.code = ev_code;
               s_next.data = ev_data;
               s_next.status = ev_status;
               if (!s_reg.proto) begin
                  // a refused variable ends the sequence before the command
                  if (ev_code != cpd_pkg::RSP_NORMAL || s_reg.opphase) begin
                     s_next.st = cpd_pkg::ST_FIN;
                  end else begin
                     s_next.opphase = (s_reg.idx == last);
                     s_next.idx = s_reg.idx + 4'h1;
                     s_next.st = cpd_pkg::ST_ISSUE;
                  end
               end else begin
                  s_next.zero = (ev_code != cpd_pkg::RSP_NORMAL);
                  s_next.wcnt = 2'h0;
                  s_next.st = cpd_pkg::ST_STORE;
               end
            end
         end
         cpd_pkg::ST_STORE: begin
            eng_wr = 1'b1;
            a = cpd_pkg::RD_AREA + 6'(item_off(s_reg.kind, s_reg.idx)) + 6'(s_reg.wcnt);
            if (s_reg.zero) begin
               s_next.mem[a] = 16'h0000;
            end else if (s_reg.wcnt == 2'h0) begin
               s_next.mem[a] = s_reg.data[15:0];
            end else if (s_reg.wcnt == 2'h1 && s_reg.kind) begin
               s_next.mem[a] = s_reg.data[31:16];
            end else begin
               s_next.mem[a] = s_reg.status;
            end
            if (s_reg.wcnt == nw - 2'h1) begin
               s_next.wcnt = 2'h0;
               if (nxt == cpd_pkg::NO_ITEM) begin
                  s_next.st = cpd_pkg::ST_FIN;
               end else begin
                  s_next.idx = nxt;
                  // after a failure the rest of the group is zeroed unread
                  s_next.st = s_reg.zero ? cpd_pkg::ST_STORE : cpd_pkg::ST_ISSUE;
               end
            end else begin
               s_next.wcnt = s_reg.wcnt + 2'h1;
            end
         end
         cpd_pkg::ST_FIN: begin
            eng_wr = 1'b1;
            a = s_reg.proto ? cpd_pkg::RD_AREA : cpd_pkg::WR_AREA;
            s_next.mem[a] = s_reg.code;
            s_next.last_mon = s_reg.code;
            s_next.busy = 1'b0;
            s_next.done = 1'b1;
            s_next.st = cpd_pkg::ST_IDLE;
         end
         default: s_next.st = cpd_pkg::ST_IDLE;
      endcase

      // ----------------------------------------------------------
      // axi4-lite read channel
      // ----------------------------------------------------------
      if (s_reg.rvalid && s_axi_rready) s_next.rvalid = 1'b0;
      if (s_axi_arvalid && s_reg.arready) begin
         s_next.rvalid = 1'b1;
         s_next.rresp = 2'b00;
         if (s_axi_araddr[11:8] == cpd_pkg::MEM_ADDR[11:8]) begin
            s_next.rdata = {16'h0000, s_reg.mem[s_axi_araddr[7:2]]};
         end else if (s_axi_araddr[11:2] == cpd_pkg::CTRL_ADDR[11:2]) begin
            s_next.rdata = 32'h0;
            s_next.rdata[cpd_pkg::CTRL_PROTO] = s_reg.proto;
            s_next.rdata[cpd_pkg::CTRL_KIND] = s_reg.kind;
            s_next.rdata[cpd_pkg::CTRL_GROUP +: 3] = s_reg.group;
            s_next.rdata[cpd_pkg::CTRL_NVARS +: 4] = s_reg.nvars;
         end else if (s_axi_araddr[11:2] == cpd_pkg::STAT_ADDR[11:2]) begin
            s_next.rdata = 32'h0;
            s_next.rdata[cpd_pkg::STAT_BUSY] = s_reg.busy;
            s_next.rdata[cpd_pkg::STAT_DONE] = s_reg.done;
            s_next.rdata[cpd_pkg::STAT_MON +: 16] = s_reg.last_mon;
         end else begin
            s_next.rdata = 32'h0;
            s_next.rresp = 2'b10;
         end
      end
      s_next.arready = !s_next.rvalid;

      // ----------------------------------------------------------
      // axi4-lite write channels
      // ----------------------------------------------------------
      if (s_reg.bvalid && s_axi_bready) s_next.bvalid = 1'b0;
      if (s_axi_awvalid && s_reg.awready) begin
         s_next.awaddr = s_axi_awaddr;
         s_next.aw_got = 1'b1;
      end
      if (s_axi_wvalid && s_reg.wready) begin
         s_next.wdata = s_axi_wdata;
         s_next.wstrb = s_axi_wstrb;
         s_next.w_got = 1'b1;
      end
      // register and memory writes wait for every cycle in which the engine owns the write port
      if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid && !eng_wr) begin
         s_next.aw_got = 1'b0;
         s_next.w_got = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = 2'b00;
         if (s_reg.awaddr[11:8] == cpd_pkg::MEM_ADDR[11:8]) begin
            if (s_reg.wstrb[0]) s_next.mem[s_reg.awaddr[7:2]][7:0] = s_reg.wdata[7:0];
            if (s_reg.wstrb[1]) s_next.mem[s_reg.awaddr[7:2]][15:8] = s_reg.wdata[15:8];
         end else if (s_reg.awaddr[11:2] == cpd_pkg::CTRL_ADDR[11:2]) begin
            // settings are frozen while an exchange runs
            if (!s_reg.busy) begin
               if (s_reg.wstrb[0]) begin
                  s_next.proto = s_reg.wdata[cpd_pkg::CTRL_PROTO];
                  s_next.kind = s_reg.wdata[cpd_pkg::CTRL_KIND];
                  s_next.group = s_reg.wdata[cpd_pkg::CTRL_GROUP +: 3];
                  if (s_reg.wdata[cpd_pkg::CTRL_START]) begin
                     s_next.busy = 1'b1;
                     s_next.done = 1'b0;
                     s_next.st = cpd_pkg::ST_START;
                  end
               end
               if (s_reg.wstrb[1]) s_next.nvars = s_reg.wdata[cpd_pkg::CTRL_NVARS +: 4];
            end
         end else if (s_reg.awaddr[11:2] != cpd_pkg::STAT_ADDR[11:2]) begin
            s_next.bresp = 2'b10;
         end
      end
      s_next.awready = !s_next.aw_got && !s_next.bvalid;
      s_next.wready = !s_next.w_got && !s_next.bvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   assign s_axi_awready = s_reg.awready;
   assign s_axi_wready = s_reg.wready;
   assign s_axi_bvalid = s_reg.bvalid;
   assign s_axi_bresp = s_reg.bresp;
   assign s_axi_arready = s_reg.arready;
   assign s_axi_rvalid = s_reg.rvalid;
   assign s_axi_rdata = s_reg.rdata;
   assign s_axi_rresp = s_reg.rresp;
   assign req_valid = s_reg.req_valid;
   assign req = s_reg.req;

endmodule

// [verif/cpd_comp_model.sv]
`timescale 1ns/100ps
module cpd_comp_model (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // component link
   input wire logic req_valid,
   output logic req_ready,
   input wire cpd_pkg::cpd_req_t req,
   output logic rsp_valid,
   output cpd_pkg::cpd_rsp_t rsp,
   // scenario control
   input wire logic clr,
   input wire logic fail_en,
   input wire logic [3:0] fail_at,
   input wire cpd_pkg::cpd_err_t fail_err,
   input wire logic fail_chk,
   input wire logic silent,
   input wire logic [3:0] lat,
   // observed traffic
   output logic [3:0] n_var,
   output logic [3:0] n_cmd,
   output logic [31:0] var1
);
   logic busy, bad;
   logic [3:0] cnt, ix;
   always_ff @(posedge aclk) begin
      rsp_valid <= 1'b0;
      // payload junk between answers
      rsp <= ~rsp;
      if (!aresetn || clr) begin
         req_ready <= 1'b0;
         busy <= 1'b0;
         n_var <= '0;
         n_cmd <= '0;
         rsp <= '0;
      end else if (!busy) begin
         // accept one cycle late so the engine must hold its request
         req_ready <= req_valid && !req_ready;
         if (req_valid && req_ready) begin
            busy <= 1'b1;
            req_ready <= 1'b0;
            cnt <= lat;
            ix <= req.index;
            bad <= fail_en && req.op != cpd_pkg::OP_COMMAND && req.index == fail_at;
            if (req.op == cpd_pkg::OP_WRITE_VAR) n_var <= n_var + 4'h1;
            if (req.op == cpd_pkg::OP_WRITE_VAR && req.index == 4'h1) var1 <= req.data;
            if (req.op == cpd_pkg::OP_COMMAND) n_cmd <= n_cmd + 4'h1;
         end
      end else if (cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
      end else begin
         busy <= 1'b0;
         rsp_valid <= !(bad && silent);
         rsp.err <= bad ? fail_err : cpd_pkg::ERR_NONE;
         rsp.chk_ok <= !(bad && fail_chk);
         rsp.resp_code <= 16'h0000;
         rsp.data <= {16'h1000 + ix, 16'h2000 + ix};
         rsp.status <= 16'h3000 + ix;
      end
   end
endmodule

// [verif/cpd_engine_props.sv]
`timescale 1ns/100ps
module cpd_engine_props (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // component link
   input wire logic req_valid,
   input wire logic req_ready,
   input wire cpd_pkg::cpd_req_t req
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_rd_ans; s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid && !s_axi_arready; endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read answer missing");
   property p_rd_hold; s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
   property p_rd_bad; s_axi_arvalid && s_axi_arready && s_axi_araddr >= 12'h108
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0; endproperty
   a_rd_bad: assert property (p_rd_bad) else $error("unmapped read not refused");
   property p_b_hold; s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_req_hold; req_valid && !req_ready |=> req_valid && $stable(req); endproperty
   a_req_hold: assert property (p_req_hold) else $error("request changed before taken");
   property p_req_gap; req_valid && req_ready |=> !req_valid [*2]; endproperty
   a_req_gap: assert property (p_req_gap) else $error("request issued before answer");
   property p_no_set; req_valid && {req.cmd, req.info} == cpd_pkg::OPCMD_NO_SET
      |-> req.op == cpd_pkg::OP_COMMAND; endproperty
   a_no_set: assert property (p_no_set) else $error("set value under 0600");
   property p_var_rng; req_valid && req.op == cpd_pkg::OP_WRITE_VAR
      |-> req.index >= 4'h1 && req.index <= 4'hC; endproperty
   a_var_rng: assert property (p_var_rng) else $error("variable number out of range");
   c_cmd: cover property (req_valid && req_ready && req.op == cpd_pkg::OP_COMMAND);
   c_item: cover property (req_valid && req_ready && req.op == cpd_pkg::OP_READ_ITEM);
   c_bad: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
bind cpd_engine cpd_engine_props u_props (.*);

// [verif/cpd_engine_bench.sv]
`timescale 1ns/100ps
module cpd_engine_bench;
   logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic req_valid, req_ready, rsp_valid, clr = 1'b0, fail_en = 1'b0, fail_chk = 1'b0;
   logic silent = 1'b0;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, var1, rd;
   logic [3:0] s_axi_wstrb = 4'hF, fail_at = '0, lat = '0, n_var, n_cmd;
   logic [1:0] s_axi_bresp, s_axi_rresp, br, rr;
   cpd_pkg::cpd_req_t req;
   cpd_pkg::cpd_rsp_t rsp;
   cpd_pkg::cpd_err_t fail_err = cpd_pkg::ERR_NONE;
   int err_count = 0, compares = 0, cyc = 0;
   cpd_engine #(.TIMEOUT_CYC(50)) dut (.*);
   cpd_comp_model model (.*);
   always #10 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 30000) begin
         err_count++;
         summarize();
      end
   end
   // ----
   // bus and check helpers
   // ----
   task check(input string what, input logic [31:0] exp, got);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task summarize;
      $display("compares %0d, err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task axw(input logic [11:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (!s_axi_awready || !s_axi_wready);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_bvalid);
      br = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task axr(input logic [11:0] a, output logic [31:0] d);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task run(input logic [31:0] ctrl);
      clr <= 1'b1;
      @(posedge aclk);
      clr <= 1'b0;
      axw(12'h100, ctrl | 32'h1);
      rd = '0;
      while (rd[1] !== 1'b1) axr(12'h104, rd);
   endtask
   task mon(input logic [11:0] a, input logic [15:0] exp);
      axr(a, rd);
      check("monitor word", {16'h0, exp}, rd);
      axr(12'h104, rd);
      check("status code", {16'h0, exp}, {16'h0, rd[31:16]});
   endtask
   task area(input logic [11:0] base, input logic [15:0] exp[]);
      foreach (exp[i]) begin
         axr(base + 12'(4 * (i + 1)), rd);
         check("read area word", {16'h0, exp[i]}, rd);
      end
   endtask
   task do_write(input logic [15:0] opw, input logic [3:0] nv, ev, ec, input logic [15:0] em);
      axw(12'h004, {16'h0, opw});
      axw(12'h008, 32'h5678);
      axw(12'h00C, 32'h1234);
      run({20'h0, nv, 8'h00});
      check("variable writes", {28'h0, ev}, {28'h0, n_var});
      check("commands", {28'h0, ec}, {28'h0, n_cmd});
      if (ev != 4'h0) check("variable one", 32'h12345678, var1);
      mon(12'h000, em);
   endtask
   // ----
   // scenarios
   // ----
   task s_write_errs;
      cpd_pkg::cpd_err_t tbl[4];
      tbl = '{cpd_pkg::ERR_ADDR_OVF, cpd_pkg::ERR_NOEXEC, cpd_pkg::ERR_CMD_CHK,
         cpd_pkg::ERR_NVM_WRITE};
      fail_en <= 1'b1;
      fail_at <= 4'h2;
      foreach (tbl[i]) begin
         fail_err <= tbl[i];
         do_write(16'h0102, 4'h3, 4'h2, 4'h0, {8'hFF, tbl[i]});
      end
      fail_err <= cpd_pkg::ERR_NONE;
      fail_chk <= 1'b1;
      do_write(16'h0102, 4'h2, 4'h2, 4'h0, 16'hFF97);
      fail_chk <= 1'b0;
      silent <= 1'b1;
      do_write(16'h0102, 4'h2, 4'h2, 4'h0, 16'hFFFF);
      silent <= 1'b0;
      fail_en <= 1'b0;
   endtask
   task s_temp;
      axw(12'h090, 32'hBEEF);
      fail_en <= 1'b1;
      fail_err <= cpd_pkg::ERR_FORMAT;
      run(32'h32);
      mon(12'h080, 16'hFF14);
      area(12'h080, '{16'h2000, 16'h3000, 16'h2001, 16'h0, 16'h0});
      fail_en <= 1'b0;
      run(32'h52);
      mon(12'h080, 16'h0000);
      area(12'h080, '{16'h2000, 16'h3000, 16'h2001, 16'h2002, 16'h2003, 16'h2004,
         16'h2005, 16'h2006, 16'h2007, 16'h3007});
   endtask
   task s_panel;
      for (int i = 4; i < 10; i++) axw(12'h080 + 12'(4 * i), 32'hFFFF);
      lat <= 4'h5;
      run(32'h46);
      lat <= 4'h0;
      area(12'h080, '{16'h2000, 16'h1000, 16'h3000, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
         16'h0, 16'h2003, 16'h1003, 16'h2004, 16'h1004, 16'h2005, 16'h1005, 16'h2006,
         16'h1006});
   endtask
   task s_misc;
      run(32'h02);
      mon(12'h080, 16'h1100);
      axr(12'h200, rd);
      check("unmapped data", 32'h0, rd);
      check("unmapped read resp", 32'h2, {30'h0, rr});
      axw(12'h200, 32'h1);
      check("unmapped write resp", 32'h2, {30'h0, br});
   endtask
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      do_write(16'h0102, 4'h2, 4'h2, 4'h1, 16'h0000);
      lat <= 4'h6;
      do_write(16'h0600, 4'h2, 4'h0, 4'h1, 16'h0000);
      lat <= 4'h0;
      s_write_errs();
      s_temp();
      s_panel();
      s_misc();
      summarize();
   end
endmodule
